// *** logic/gpf_pkg.sv ***
// gpf_pkg: constants, register map and carrier types of the port control
// block; assumes an apb slave with 32-bit data and 12-bit byte addresses.
package gpf_pkg;

  // port groups built here, pins per group
  localparam int NUM_GRP  = 2;
  localparam int GRP_PINS = 8;

  // per-group register offsets inside a group window
  localparam logic [2:0] REG_DATA     = 3'h0;
  localparam logic [2:0] REG_IO_EN    = 3'h1;
  localparam logic [2:0] REG_PULL     = 3'h2;
  localparam logic [2:0] REG_IRQ_FLAG = 3'h3;
  localparam logic [2:0] REG_IRQ_CTL  = 3'h4;
  localparam logic [2:0] REG_FILT_EN  = 3'h5;
  localparam logic [2:0] REG_MODE_SEL = 3'h6;
  localparam logic [2:0] REG_FUNC_SEL = 3'h7;

  // group window: byte address = group * 0x20 + register * 4
  localparam logic [11:0] GRP_STRIDE   = 12'h020;
  localparam logic [11:0] ADDR_CLK_CTL = 12'h100;
  localparam logic [11:0] ADDR_SUMMARY = 12'h104;

  // clock control field positions
  localparam int CLK_SRC_LSB  = 0;
  localparam int KEY_RST_LSB  = 2;
  localparam int CLK_DIV_LSB  = 4;
  localparam int DBG_RUN_BIT  = 8;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;

  // oscillator sources that exist; codes with a zero bit are refused
  localparam logic [3:0] SRC_PRESENT = 4'hF;

  // key-entry reset codes
  localparam logic [1:0] KEY_OFF  = 2'h0;
  localparam logic [1:0] KEY_P1_0 = 2'h1;
  localparam logic [1:0] KEY_P2_0 = 2'h2;
  localparam logic [1:0] KEY_P3_0 = 2'h3;

  // pad controls of one port group
  typedef struct packed {
    logic [7:0]  drive;
    logic [7:0]  drive_en;
    logic [7:0]  pull_en;
    logic [7:0]  pull_up;
    logic [7:0]  periph_sel;
    logic [15:0] func_code;
  } gpf_pads_t;

  // fields of the clock control register
  typedef struct packed {
    logic       run_in_debug;
    logic [3:0] filter_clock_divider;
    logic [1:0] key_reset_config;
    logic [1:0] filter_clock_source;
  } gpf_clk_ctl_t;

endpackage

// *** logic/gpf_port_ctrl.sv ***
// gpf_port_ctrl: port groups with pull gating, edge interrupts, chattering
// filter, function select, filter clock control and key-entry reset.
// assumes pins and oscillator ticks are synchronous to pclk.
`timescale 1ns/100ps

module gpf_port_ctrl
  import gpf_pkg::*;
(
  // apb slave
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // system
  input  wire logic                              prot_released,
  input  wire logic                              debug_mode,
  input  wire logic [3:0]                        osc_tick,
  // pins
  input  wire logic [NUM_GRP-1:0][GRP_PINS-1:0]  pin_in,
  output gpf_pads_t [NUM_GRP-1:0]                pads,
  // requests
  output logic      [NUM_GRP-1:0]                group_irq_pending,
  output logic                                   key_reset_req
);

  logic [NUM_GRP-1:0][7:0]  dat_out_ff;
  logic [NUM_GRP-1:0][7:0]  in_en_ff;
  logic [NUM_GRP-1:0][7:0]  out_en_ff;
  logic [NUM_GRP-1:0][7:0]  pull_up_ff;
  logic [NUM_GRP-1:0][7:0]  pull_en_ff;
  logic [NUM_GRP-1:0][7:0]  pin_irq_cause_flag_ff;
  logic [NUM_GRP-1:0][7:0]  irq_edge_select_ff;
  logic [NUM_GRP-1:0][7:0]  pin_irq_enable_ff;
  logic [NUM_GRP-1:0][7:0]  debounce_enable_ff;
  logic [NUM_GRP-1:0][7:0]  peripheral_mode_select_ff;
  logic [NUM_GRP-1:0][15:0] pin_function_code_ff;
  logic [NUM_GRP-1:0][7:0]  smp_ff;
  logic [NUM_GRP-1:0][7:0]  filt_ff;
  logic [NUM_GRP-1:0][7:0]  prev_ff;
  logic [NUM_GRP-1:0][7:0]  eff_in;
  gpf_pads_t [NUM_GRP-1:0]  pads_ff;
  logic [NUM_GRP-1:0]       irq_ff;
  gpf_clk_ctl_t             clk_ctl_ff;
  logic [14:0]              div_cnt_ff;
  logic                     port_tick_ff;
  logic                     key_reset_ff;
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic [31:0]              rd_data;
  logic                     rd_err;
  logic                     wr_en;
  logic                     grp_hit;
  logic [2:0]               grp_idx;
  logic [2:0]               reg_idx;
  logic                     sel_tick;
  logic                     clk_run;
  logic [14:0]              div_mask;
  logic [3:0]               key_mask;
  logic [12:0]              summary;

  assign wr_en    = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign grp_idx  = paddr[7:5];
  assign reg_idx  = paddr[4:2];
  assign grp_hit  = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0)
                    && (grp_idx < 3'(NUM_GRP));

  // apb answer: one wait state, data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= rd_err;
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
  end

  // read mux and address check
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (grp_hit) begin
      unique case (reg_idx)
        REG_DATA:     rd_data = {16'h0000, dat_out_ff[grp_idx],
                                 pin_in[grp_idx] & in_en_ff[grp_idx]
                                 & ~peripheral_mode_select_ff[grp_idx]};
        REG_IO_EN:    rd_data = {16'h0000, in_en_ff[grp_idx],
                                 out_en_ff[grp_idx]};
        REG_PULL:     rd_data = {16'h0000, pull_up_ff[grp_idx],
                                 pull_en_ff[grp_idx]};
        REG_IRQ_FLAG: rd_data = {24'h000000,
                                 pin_irq_cause_flag_ff[grp_idx]};
        REG_IRQ_CTL:  rd_data = {16'h0000, irq_edge_select_ff[grp_idx],
                                 pin_irq_enable_ff[grp_idx]};
        REG_FILT_EN:  rd_data = {24'h000000, debounce_enable_ff[grp_idx]};
        REG_MODE_SEL: rd_data = {24'h000000,
                                 peripheral_mode_select_ff[grp_idx]};
        REG_FUNC_SEL: rd_data = {16'h0000, pin_function_code_ff[grp_idx]};
      endcase
    end else if (paddr == ADDR_CLK_CTL) begin
      rd_data = {23'h000000, clk_ctl_ff};
    end else if (paddr == ADDR_SUMMARY) begin
      rd_data = {19'h00000, summary};
    end else begin
      rd_err = 1'b1;
    end
  end

  // clock control, guarded by write protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl_ff <= '0;
    end else if (wr_en && paddr == ADDR_CLK_CTL && prot_released) begin
      clk_ctl_ff.run_in_debug         <= pwdata[DBG_RUN_BIT];
      clk_ctl_ff.filter_clock_divider <= pwdata[CLK_DIV_LSB +: 4];
      clk_ctl_ff.key_reset_config     <= pwdata[KEY_RST_LSB +: 2];
      if (SRC_PRESENT[pwdata[CLK_SRC_LSB +: 2]]) begin
        clk_ctl_ff.filter_clock_source <= pwdata[CLK_SRC_LSB +: 2];
      end
    end
  end

  // port clock: selected source, divided by a power of two
  assign sel_tick = osc_tick[clk_ctl_ff.filter_clock_source];
  assign clk_run  = ~debug_mode | clk_ctl_ff.run_in_debug;
  assign div_mask = 15'((16'h0001 << clk_ctl_ff.filter_clock_divider)
                        - 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff   <= 15'h0000;
      port_tick_ff <= 1'b0;
    end else begin
      port_tick_ff <= sel_tick & clk_run
                      & ((div_cnt_ff & div_mask) == div_mask);
      if (sel_tick && clk_run) begin
        div_cnt_ff <= div_cnt_ff + 15'h0001;
      end
    end
  end

  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] set_ev;
    logic [7:0] clr_wr;
    logic       hit;

    assign hit = wr_en && grp_hit && (grp_idx == 3'(g));
    assign eff_in[g] = (debounce_enable_ff[g] & filt_ff[g])
                       | (~debounce_enable_ff[g] & pin_in[g]);
    assign rise   = eff_in[g] & ~prev_ff[g];
    assign fall   = ~eff_in[g] & prev_ff[g];
    assign set_ev = ((irq_edge_select_ff[g] & fall)
                     | (~irq_edge_select_ff[g] & rise))
                    & ~peripheral_mode_select_ff[g];
    assign clr_wr = (hit && reg_idx == REG_IRQ_FLAG) ? pwdata[7:0] : 8'h00;

    // software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dat_out_ff[g]                <= RST_BYTE;
        in_en_ff[g]                  <= RST_BYTE;
        out_en_ff[g]                 <= RST_BYTE;
        pull_up_ff[g]                <= RST_BYTE;
        pull_en_ff[g]                <= RST_BYTE;
        irq_edge_select_ff[g]        <= RST_BYTE;
        pin_irq_enable_ff[g]         <= RST_BYTE;
        debounce_enable_ff[g]        <= RST_BYTE;
        peripheral_mode_select_ff[g] <= RST_BYTE;
        pin_function_code_ff[g]      <= RST_HALF;
      end else if (hit) begin
        unique case (reg_idx)
          REG_DATA:     dat_out_ff[g] <= pwdata[15:8];
          REG_IO_EN: begin
            in_en_ff[g]  <= pwdata[15:8];
            out_en_ff[g] <= pwdata[7:0];
          end
          REG_PULL: begin
            pull_up_ff[g] <= pwdata[15:8];
            pull_en_ff[g] <= pwdata[7:0];
          end
          REG_IRQ_CTL: begin
            irq_edge_select_ff[g] <= pwdata[15:8];
            pin_irq_enable_ff[g]  <= pwdata[7:0];
          end
          REG_FILT_EN:  debounce_enable_ff[g] <= pwdata[7:0];
          REG_MODE_SEL: peripheral_mode_select_ff[g] <= pwdata[7:0];
          REG_FUNC_SEL: pin_function_code_ff[g] <= pwdata[15:0];
          REG_IRQ_FLAG: ;
        endcase
      end
    end

    // cause flags: a new edge wins over a write-1 clear
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_irq_cause_flag_ff[g] <= RST_BYTE;
      end else begin
        pin_irq_cause_flag_ff[g] <= (pin_irq_cause_flag_ff[g] & ~clr_wr)
                                    | set_ev;
      end
    end

    // chattering filter: output follows two equal port clock samples;
    // a bypassed pin keeps the filter loaded so enabling it makes no edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        smp_ff[g]  <= RST_BYTE;
        filt_ff[g] <= RST_BYTE;
      end else begin
        for (int b = 0; b < GRP_PINS; b++) begin
          if (!debounce_enable_ff[g][b]) begin
            smp_ff[g][b]  <= pin_in[g][b];
            filt_ff[g][b] <= pin_in[g][b];
          end else if (port_tick_ff) begin
            smp_ff[g][b] <= pin_in[g][b];
            if (smp_ff[g][b] == pin_in[g][b]) begin
              filt_ff[g][b] <= pin_in[g][b];
            end
          end
        end
      end
    end

    // edge reference, pad controls and request
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev_ff[g] <= RST_BYTE;
        pads_ff[g] <= '0;
        irq_ff[g]  <= 1'b0;
      end else begin
        prev_ff[g]            <= eff_in[g];
        pads_ff[g].drive      <= dat_out_ff[g];
        pads_ff[g].drive_en   <= out_en_ff[g]
                                 & ~peripheral_mode_select_ff[g];
        pads_ff[g].pull_en    <= pull_en_ff[g] & ~out_en_ff[g]
                                 & ~peripheral_mode_select_ff[g];
        pads_ff[g].pull_up    <= pull_up_ff[g]
                                 & ~peripheral_mode_select_ff[g];
        pads_ff[g].periph_sel <= peripheral_mode_select_ff[g];
        for (int b = 0; b < GRP_PINS; b++) begin
          pads_ff[g].func_code[2*b +: 2] <=
            peripheral_mode_select_ff[g][b]
              ? pin_function_code_ff[g][2*b +: 2] : 2'h0;
        end
        irq_ff[g] <= |(pin_irq_cause_flag_ff[g] & pin_irq_enable_ff[g]);
      end
    end
  end

  // summary bits: only enabled pins count
  always_comb begin
    summary = 13'h0000;
    for (int g = 0; g < NUM_GRP; g++) begin
      summary[g] = |(pin_irq_cause_flag_ff[g] & pin_irq_enable_ff[g]);
    end
  end

  // key-entry reset on port 0, after filtering where enabled
  always_comb begin
    unique case (clk_ctl_ff.key_reset_config)
      KEY_OFF:  key_mask = 4'h0;
      KEY_P1_0: key_mask = 4'h3;
      KEY_P2_0: key_mask = 4'h7;
      KEY_P3_0: key_mask = 4'hF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_reset_ff <= 1'b0;
    end else begin
      key_reset_ff <= (key_mask != 4'h0)
                      && ((eff_in[0][3:0] & key_mask) == 4'h0);
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign pads              = pads_ff;
  assign group_irq_pending = irq_ff;
  assign key_reset_req     = key_reset_ff;

endmodule

// *** verification/gpf_chk.sv ***
// gpf_chk: apb timing, pull gating and group pending clear checks.
// assumes it is bound to gpf_port_ctrl.
`timescale 1ns/100ps
module gpf_chk
  import gpf_pkg::*;
(
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic      [31:0]       prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // pads and requests
  input wire gpf_pads_t [NUM_GRP-1:0] pads,
  input wire logic      [NUM_GRP-1:0] group_irq_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_wr_done;
    $past(pready && pwrite, 1) || $past(pready && pwrite, 2);
  endsequence

  property p_one_wait;
    s_wait |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_setup_quiet;
    psel && !penable |-> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_no_pull_drive;
    ((pads[0].pull_en & pads[0].drive_en) |
     (pads[1].pull_en & pads[1].drive_en)) == 8'h00;
  endproperty
  property p_no_pull_periph;
    ((pads[0].pull_en & pads[0].periph_sel) |
     (pads[1].pull_en & pads[1].periph_sel)) == 8'h00;
  endproperty
  property p_pend_fall;
    |($past(group_irq_pending) & ~group_irq_pending) |-> s_wr_done;
  endproperty

  a_one_wait: assert property (p_one_wait)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");
  a_setup_quiet: assert property (p_setup_quiet)
    else $error("pready high in setup cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("prdata not zero outside answer");
  a_no_pull_drive: assert property (p_no_pull_drive)
    else $error("pull applied on a driven pin");
  a_no_pull_periph: assert property (p_no_pull_periph)
    else $error("pull applied on a peripheral pin");
  a_pend_fall: assert property (p_pend_fall)
    else $error("group pending fell without a write");
endmodule

bind gpf_port_ctrl gpf_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pads(pads), .group_irq_pending(group_irq_pending)
);

// *** verification/gpf_pins.sv ***
// gpf_pins: far-side model of the pins of every port group.
// assumes pads come from flops clocked by pclk.
`timescale 1ns/100ps
module gpf_pins
  import gpf_pkg::*;
(
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // pad controls from the block
  input  wire gpf_pads_t [NUM_GRP-1:0]          pads,
  // external drivers set by the bench
  input  wire logic [NUM_GRP-1:0][GRP_PINS-1:0] ext_on,
  input  wire logic [NUM_GRP-1:0][GRP_PINS-1:0] ext_lvl,
  // pin levels seen by the block
  output logic      [NUM_GRP-1:0][GRP_PINS-1:0] pin_in
);
  logic [GRP_PINS-1:0] float_ff;

  // an undriven, unpulled pin wanders every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_ff <= 8'h55;
    end else begin
      float_ff <= ~float_ff;
    end
  end

  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      for (int b = 0; b < GRP_PINS; b++) begin
        if (pads[g].drive_en[b]) begin
          pin_in[g][b] = pads[g].drive[b];
        end else if (ext_on[g][b]) begin
          pin_in[g][b] = ext_lvl[g][b];
        end else if (pads[g].pull_en[b]) begin
          pin_in[g][b] = pads[g].pull_up[b];
        end else begin
          pin_in[g][b] = float_ff[b];
        end
      end
    end
  end
endmodule

// *** verification/gpf_port_ctrl_test.sv ***
// gpf_port_ctrl_test: self-checking bench of the port control block.
// assumes gpf_pins on the pin side and an apb master in the bench.
`timescale 1ns/100ps
module gpf_port_ctrl_test import gpf_pkg::*; ();
  logic                             pclk, presetn, psel, penable, pwrite;
  logic                             pready, pslverr, key_reset_req;
  logic                             prot_released, debug_mode, tick_on;
  logic [11:0]                      paddr;
  logic [31:0]                      pwdata, prdata, v;
  logic [3:0]                       osc_tick;
  logic [15:0]                      rnd;
  logic [NUM_GRP-1:0][GRP_PINS-1:0] pin_in, ext_on, ext_lvl;
  logic [NUM_GRP-1:0]               group_irq_pending;
  gpf_pads_t [NUM_GRP-1:0]          pads;
  logic [33:0]                      q[$];
  int                               err_count, check_count;
  localparam logic [15:0] MSK [8] = '{16'hFF00, 16'hFFFF, 16'hFFFF,
    16'h0000, 16'hFFFF, 16'h00FF, 16'h00FF, 16'hFFFF};

  gpf_port_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prot_released(prot_released), .debug_mode(debug_mode),
    .osc_tick(osc_tick), .pin_in(pin_in), .pads(pads),
    .group_irq_pending(group_irq_pending), .key_reset_req(key_reset_req));
  gpf_pins u_pins (.pclk(pclk), .presetn(presetn), .pads(pads),
    .ext_on(ext_on), .ext_lvl(ext_lvl), .pin_in(pin_in));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] ad(input int g, input logic [2:0] r);
    return 12'(g) * GRP_STRIDE + {7'h0, r, 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // e: {compare data, expected pslverr, expected prdata}
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(e);
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    rnd <= lfsr(rnd);
    osc_tick <= tick_on ? rnd[3:0] : 4'h0;
    if (pready === 1'b1) begin
      if (q[0][33]) check(prdata, q[0][31:0]);
      check(pslverr, q[0][32]);
      q.delete(0);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, prot_released, debug_mode} = 6'h0;
    {tick_on, paddr, pwdata, ext_lvl} = '0;
    ext_on = '1;
    rnd = 16'h0033;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int g = 0; g < NUM_GRP; g++)
      for (int r = 0; r < 8; r++) rd(ad(g, r), 32'h0);
    rd(ADDR_CLK_CTL, 32'h0);
    rd(ADDR_SUMMARY, 32'h0);
    apb(1'b0, 12'h200, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h204, 32'h5, {2'b01, 32'h0});
    for (int g = 0; g < NUM_GRP; g++)
      for (int r = 0; r < 8; r++) begin
        v = {rnd, rnd};
        wr(ad(g, r), v);
        if (r != 3) rd(ad(g, r), v & {16'h0, MSK[r]});
      end
    for (int g = 0; g < NUM_GRP; g++)
      for (int r = 0; r < 8; r++) wr(ad(g, r), r == 3 ? 32'hFF : 32'h0);
    // pull gating on group 0, pins left to the pad model
    ext_on[0] <= 8'h00;
    wr(ad(0, 1), 32'hFF01);
    wr(ad(0, 2), 32'h0FFF);
    wr(ad(0, 6), 32'h02);
    wr(ad(0, 7), 32'h0C);
    repeat (2) @(posedge pclk);
    check(pads[0].pull_en, 8'hFC);
    check(pads[0].pull_up & pads[0].pull_en, 8'h0C);
    check(pads[0].periph_sel, 8'h02);
    check(pads[0].func_code, 16'h000C);
    rd(ad(0, 0), 32'h0C);
    ext_on[0] <= 8'hFF;
    for (int r = 1; r < 8; r++) wr(ad(0, r), r == 3 ? 32'hFF : 32'h0);
    // edge interrupts on group 1, pin 3 on falling edge
    wr(ad(1, 1), 32'hFF00);
    wr(ad(1, 4), 32'h0800);
    wr(ad(1, 3), 32'hFF);
    ext_lvl[1] <= 8'hFF;
    repeat (4) @(posedge pclk);
    rd(ad(1, 3), 32'hF7);
    rd(ADDR_SUMMARY, 32'h0);
    check(group_irq_pending, 2'b00);
    ext_lvl[1] <= 8'h00;
    repeat (4) @(posedge pclk);
    rd(ad(1, 3), 32'hFF);
    wr(ad(1, 3), 32'h0F);
    rd(ad(1, 3), 32'hF0);
    wr(ad(1, 3), 32'hFF);
    wr(ad(1, 4), 32'h0801);
    check(group_irq_pending, 2'b00);
    ext_lvl[1] <= 8'h01;
    repeat (4) @(posedge pclk);
    check(group_irq_pending, 2'b10);
    rd(ADDR_SUMMARY, 32'h2);
    wr(ad(1, 3), 32'h01);
    repeat (2) @(posedge pclk);
    check(group_irq_pending, 2'b00);
    rd(ADDR_SUMMARY, 32'h0);
    // clock control and key-entry reset on group 0
    wr(ad(0, 1), 32'hFF00);
    ext_lvl[0] <= 8'hFF;
    wr(ADDR_CLK_CTL, 32'h0105);
    rd(ADDR_CLK_CTL, 32'h0);
    prot_released <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = 32'((k << 4) | (k << 2) | k);
      wr(ADDR_CLK_CTL, v);
      rd(ADDR_CLK_CTL, v);
      ext_lvl[0] <= 8'hF0;
      repeat (3) @(posedge pclk);
      check(key_reset_req, k != 0);
      ext_lvl[0] <= 8'hF0 | (8'h01 << k);
      repeat (3) @(posedge pclk);
      check(key_reset_req, 1'b0);
      ext_lvl[0] <= 8'hFF;
      repeat (2) @(posedge pclk);
    end
    wr(ad(0, 5), 32'h03);
    wr(ADDR_CLK_CTL, 32'h0015);
    ext_lvl[0] <= 8'hFC;
    repeat (10) @(posedge pclk);
    check(key_reset_req, 1'b0);
    tick_on <= 1'b1;
    repeat (300) if (key_reset_req !== 1'b1) @(posedge pclk);
    check(key_reset_req, 1'b1);
    debug_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_lvl[0] <= 8'hFF;
    repeat (40) @(posedge pclk);
    check(key_reset_req, 1'b1);
    debug_mode <= 1'b0;
    repeat (300) if (key_reset_req !== 1'b0) @(posedge pclk);
    check(key_reset_req, 1'b0);
    wrap_up();
  end
endmodule
